// file: core/pwm_edge_dead_time_trim.sv
// Functional notes
// - the polarity bit of each edge field, bit 7 upper and bit 3 lower, gives 0 positive and 1 negative offset.
// - edge three moves by first register bits 6:4 times 5 ns, 0 to 35 ns.
// - edge four moves by first register bits 2:0 times 5 ns, 0 to 35 ns.
// - edge five moves by second register bits 6:4 times 5 ns, 0 to 35 ns.
// - edge six moves by second register bits 2:0 times 5 ns, 0 to 35 ns.
`timescale 1ns/1ns
module pwm_edge_dead_time_trim
  import edge_trim_pkg::*;
(
  // system
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  output logic                          wb_err_o,
  // scheduler side
  input  wire logic [TIME_W*NUM_EDGES-1:0] nominal_time,
  output logic      [TIME_W*NUM_EDGES-1:0] trimmed_time,
  output logic      [NUM_EDGES-1:0]        edge_negative,
  output logic      [OFFSET_W*NUM_EDGES-1:0] edge_code
);
  logic [7:0]                    trim_a;
  logic [7:0]                    trim_b;
  logic [1:0]                    edge_sel;
  logic [TIME_W*NUM_EDGES-1:0]   trimmed_q;
  logic [NUM_EDGES-1:0]          neg_q;
  logic [OFFSET_W*NUM_EDGES-1:0] code_q;
  logic [31:0]                   rd_q;
  logic                          ack_q;
  logic                          err_q;

  wire logic                     req;
  wire logic                     hit_a;
  wire logic                     hit_b;
  wire logic                     hit_sel;
  wire logic                     hit_nom;
  wire logic                     hit_trim;
  wire logic                     hit_stat;
  wire logic                     mapped;
  wire logic                     wr_a;
  wire logic                     wr_b;
  wire logic                     wr_sel;
  wire logic [31:0]              next_rd;
  wire logic [NUM_EDGES-1:0]     pol;
  wire logic [CODE_W*NUM_EDGES-1:0] codes;
  wire logic [TIME_W*NUM_EDGES-1:0] next_trimmed;
  wire logic [TIME_W-1:0]        sel_nom;
  wire logic [TIME_W-1:0]        sel_trim;
  wire logic [OFFSET_W*NUM_EDGES-1:0] code_pad;

  // bus decode, one ack per mapped request and one err per unmapped one, dropped the cycle after
  assign req      = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
  assign hit_a    = wb_adr_i == ADDR_TRIM_A;
  assign hit_b    = wb_adr_i == ADDR_TRIM_B;
  assign hit_sel  = wb_adr_i == ADDR_EDGE_SEL;
  assign hit_nom  = wb_adr_i == ADDR_NOMINAL;
  assign hit_trim = wb_adr_i == ADDR_TRIMMED;
  assign hit_stat = wb_adr_i == ADDR_STATUS;
  assign mapped   = hit_a | hit_b | hit_sel | hit_nom | hit_trim | hit_stat;
  assign wr_a     = req & wb_we_i & hit_a & wb_sel_i[0];
  assign wr_b     = req & wb_we_i & hit_b & wb_sel_i[0];
  assign wr_sel   = req & wb_we_i & hit_sel & wb_sel_i[0];

  // edge fields: index 0..3 are edges three..six
  assign pol   = {trim_b[LOWER_POL_BIT], trim_b[UPPER_POL_BIT],
                  trim_a[LOWER_POL_BIT], trim_a[UPPER_POL_BIT]};
  assign codes = {trim_b[LOWER_CODE_LSB +: CODE_W],
                  trim_b[UPPER_CODE_LSB +: CODE_W],
                  trim_a[LOWER_CODE_LSB +: CODE_W],
                  trim_a[UPPER_CODE_LSB +: CODE_W]};

  genvar g;
  generate
    for (g = 0; g < NUM_EDGES; g = g + 1) begin : g_edge
      edge_offset_calc u_calc (
        .polarity     (pol[g]),
        .code         (codes[g*CODE_W +: CODE_W]),
        .nominal      (nominal_time[g*TIME_W +: TIME_W]),
        .trimmed      (next_trimmed[g*TIME_W +: TIME_W]),
        .offset_ticks ()
      );
      // code widened to the scheduler nibble, top bits zero
      assign code_pad[g*OFFSET_W +: OFFSET_W] = {{(OFFSET_W-CODE_W){1'b0}}, codes[g*CODE_W +: CODE_W]};
    end
  endgenerate

  assign sel_nom  = nominal_time[edge_sel*TIME_W +: TIME_W];
  assign sel_trim = trimmed_q[edge_sel*TIME_W +: TIME_W];
  assign next_rd  = hit_a    ? {24'h000000, trim_a} :
                    hit_b    ? {24'h000000, trim_b} :
                    hit_sel  ? {30'h00000000, edge_sel} :
                    hit_nom  ? {16'h0000, sel_nom} :
                    hit_trim ? {16'h0000, sel_trim} :
                    hit_stat ? {28'h0000000, neg_q} : 32'h00000000;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trim_a <= TRIM_RESET;
      trim_b <= TRIM_RESET;
      edge_sel <= 2'h0;
    end else begin
      if (wr_a) trim_a <= wb_dat_i[7:0];
      if (wr_b) trim_b <= wb_dat_i[7:0];
      if (wr_sel) edge_sel <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rd_q  <= 32'h00000000;
    end else begin
      ack_q <= req & mapped;
      err_q <= req & ~mapped;
      rd_q  <= (req & ~wb_we_i) ? next_rd : 32'h00000000;
    end
  end

  // registered edge outputs for the scheduler
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trimmed_q <= '0;
      neg_q     <= '0;
      code_q    <= '0;
    end else begin
      trimmed_q <= next_trimmed;
      neg_q     <= pol;
      code_q    <= code_pad;
    end
  end

  assign wb_dat_o      = rd_q;
  assign wb_ack_o      = ack_q;
  assign wb_err_o      = err_q;
  assign trimmed_time  = trimmed_q;
  assign edge_negative = neg_q;
  assign edge_code     = code_q;
endmodule : pwm_edge_dead_time_trim

// file: shared/edge_trim_pkg.sv
package edge_trim_pkg;
  // register map, byte addresses on the bus
  localparam logic [7:0] ADDR_TRIM_A      = 8'h6A;
  localparam logic [7:0] ADDR_TRIM_B      = 8'h6B;
  localparam logic [7:0] ADDR_NOMINAL     = 8'h70;
  localparam logic [7:0] ADDR_EDGE_SEL    = 8'h74;
  localparam logic [7:0] ADDR_TRIMMED     = 8'h78;
  localparam logic [7:0] ADDR_STATUS      = 8'h7C;
  // field positions
  localparam int UPPER_POL_BIT            = 7;
  localparam int UPPER_CODE_LSB           = 4;
  localparam int LOWER_POL_BIT            = 3;
  localparam int LOWER_CODE_LSB           = 0;
  localparam int CODE_W                   = 3;
  // reset values
  localparam logic [7:0] TRIM_RESET       = 8'h00;
  localparam logic [15:0] NOMINAL_RESET   = 16'h0000;
  // timing
  localparam int STEP_NS                  = 5;
  localparam int TICK_PS                  = 625;
  localparam int TIME_W                   = 16;
  localparam int OFFSET_W                 = 4;
  localparam int NUM_EDGES                = 4;
  localparam logic [TIME_W-1:0] TIME_MAX  = 16'hFFFF;
endpackage : edge_trim_pkg

// file: core/edge_offset_calc.sv
`timescale 1ns/1ns
module edge_offset_calc
  import edge_trim_pkg::*;
(
  // trim field
  input  wire logic                polarity,
  input  wire logic [CODE_W-1:0]   code,
  // time in scheduler ticks
  input  wire logic [TIME_W-1:0]   nominal,
  output logic      [TIME_W-1:0]   trimmed,
  output logic      [TIME_W-1:0]   offset_ticks
);
  // one code step expressed in scheduler ticks, rounded down
  localparam int STEP_TICKS = (STEP_NS * 1000) / TICK_PS;
  localparam logic [TIME_W-1:0] STEP_T = TIME_W'(STEP_TICKS);

  wire logic [TIME_W:0] sum;
  wire logic [TIME_W:0] diff;

  assign offset_ticks = TIME_W'({13'h0000, code} * STEP_T);
  // positive adds, negative subtracts, saturate at the range ends
  assign sum     = {1'b0, nominal} + {1'b0, offset_ticks};
  assign diff    = {1'b0, nominal} - {1'b0, offset_ticks};
  assign trimmed = polarity ? (diff[TIME_W] ? '0 : diff[TIME_W-1:0])
                            : (sum[TIME_W] ? TIME_MAX : sum[TIME_W-1:0]);
endmodule : edge_offset_calc

// file: verification/pwm_edge_dead_time_trim_chk.sv
`timescale 1ns/1ns
module pwm_edge_dead_time_trim_chk
  import edge_trim_pkg::*;
(
  // system
  input wire logic        clk,
  input wire logic        sys_rst,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // scheduler
  input wire logic [63:0] nominal_time,
  input wire logic [63:0] trimmed_time,
  input wire logic [3:0]  edge_negative,
  input wire logic [15:0] edge_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire take = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & !wb_ack_o & !wb_err_o;
  wire wr_a = take & (wb_adr_i == ADDR_TRIM_A);
  wire wr_b = take & (wb_adr_i == ADDR_TRIM_B);
  function automatic logic [15:0] sat(logic [15:0] n, logic g, logic [3:0] c);
    int v;
    v = g ? int'(n) - int'(c) * 8 : int'(n) + int'(c) * 8;
    return v < 0 ? 16'h0000 : v > 65535 ? 16'hFFFF : v[15:0];
  endfunction : sat
  property p_pol; wr_a |=> ##1 edge_negative[1:0] == {$past(wb_dat_i[3], 2), $past(wb_dat_i[7], 2)}; endproperty
  a_pol: assert property (p_pol) else $error("polarity not taken from write");
  property p_c3; wr_a |=> ##1 edge_code[3:0] == {1'b0, $past(wb_dat_i[6:4], 2)}; endproperty
  a_c3: assert property (p_c3) else $error("edge three code wrong");
  property p_c4; wr_a |=> ##1 edge_code[7:4] == {1'b0, $past(wb_dat_i[2:0], 2)}; endproperty
  a_c4: assert property (p_c4) else $error("edge four code wrong");
  property p_c5; wr_b |=> ##1 edge_code[11:8] == {1'b0, $past(wb_dat_i[6:4], 2)}; endproperty
  a_c5: assert property (p_c5) else $error("edge five code wrong");
  property p_c6; wr_b |=> ##1 edge_code[15:12] == {1'b0, $past(wb_dat_i[2:0], 2)}; endproperty
  a_c6: assert property (p_c6) else $error("edge six code wrong");
  property p_trim; !$past(sys_rst) |-> trimmed_time[63:48] == sat($past(nominal_time[63:48]),
    edge_negative[3], edge_code[15:12]); endproperty
  a_trim: assert property (p_trim) else $error("trimmed time wrong");
endmodule : pwm_edge_dead_time_trim_chk

// file: verification/pwm_edge_dead_time_trim_tb.sv
`timescale 1ns/1ns
module pwm_edge_dead_time_trim_tb;
  import edge_trim_pkg::*;
  logic clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, rerr;
  logic [7:0] adr = 0, d;
  logic [3:0] sel = 0, neg, code;
  logic [31:0] dat = 0, rdat;
  logic [63:0] nominal_time = {16'hFFF0, 16'h8000, 16'h1000, 16'h0010};
  logic [63:0] trimmed_time;
  logic [31:0] wb_dat_o;
  logic [15:0] edge_code, r;
  logic [3:0] edge_negative;
  logic wb_ack_o, wb_err_o;
  int errors = 0, comparisons = 0, b;
  always #10 clk = ~clk;
  pwm_edge_dead_time_trim i_pwm_edge_dead_time_trim (.clk, .sys_rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .wb_err_o,
    .nominal_time, .trimmed_time, .edge_negative, .edge_code);
  function automatic logic [15:0] expt(logic [15:0] n, logic g, logic [3:0] c);
    int v;
    v = g ? int'(n) - int'(c) * (STEP_NS * 1000 / TICK_PS) : int'(n) + int'(c) * (STEP_NS * 1000 / TICK_PS);
    return v < 0 ? 16'h0000 : v > 65535 ? 16'hFFFF : v[15:0];
  endfunction : expt
  task bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] x);
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, x};
    do @(posedge clk);
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rdat = wb_dat_o;
    rerr = wb_err_o;
    {cyc, stb} <= 2'b00;
  endtask : bus
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  initial begin
    #100000;
    errors++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    bus(0, ADDR_TRIM_A, 4'hF, 0);
    chk("reset trim", {24'h0, TRIM_RESET}, rdat);
    chk("reset code", 0, edge_code);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = {i[0], i[2:0], ~i[0], ~i[2:0]};
      bus(1, ADDR_TRIM_A, 4'hF, {24'h0, d});
      bus(1, ADDR_TRIM_B, 4'h1, {24'h0, ~d});
      repeat (2) @(posedge clk);
      #1 r = {~d, d};
      for (int k = 0; k < 4; k++) begin
        b = (k / 2) * 8 + ((k % 2) ? 0 : 4);
        neg = r[b + 3];
        code = {1'b0, r[b +: 3]};
        chk("negative", neg, edge_negative[k]);
        chk("code", code, edge_code[k * 4 +: 4]);
        chk("trimmed", expt(nominal_time[k * 16 +: 16], neg[0], code), trimmed_time[k * 16 +: 16]);
      end
      bus(0, ADDR_TRIM_A, 4'hF, 0);
      chk("read a", {24'h0, d}, rdat);
    end
    $display("test sweep done");
    bus(1, ADDR_TRIM_B, 4'hE, 32'h5A);
    bus(0, ADDR_TRIM_B, 4'hF, 0);
    chk("sel write", 32'h0F, rdat);
    bus(0, 8'h00, 4'hF, 0);
    chk("unmapped", 1, rerr);
    $display("test refusal done");
    bus(1, ADDR_EDGE_SEL, 4'h1, 32'h3);
    bus(0, ADDR_EDGE_SEL, 4'hF, 0);
    chk("edge select", 32'h3, rdat);
    bus(0, ADDR_NOMINAL, 4'hF, 0);
    chk("nominal read", {16'h0, nominal_time[63:48]}, rdat);
    bus(0, ADDR_TRIMMED, 4'hF, 0);
    chk("trimmed read", {16'h0, expt(nominal_time[63:48], 1'b1, 4'h7)}, rdat);
    bus(0, ADDR_STATUS, 4'hF, 0);
    chk("status read", 32'h9, rdat);
    $display("test map done");
    test_done();
  end
endmodule : pwm_edge_dead_time_trim_tb
bind pwm_edge_dead_time_trim pwm_edge_dead_time_trim_chk i_chk (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o, .nominal_time, .trimmed_time,
  .edge_negative, .edge_code);
